// *** logic/priority_interrupt_arbiter.sv ***
`timescale 1ns/1ps
module priority_interrupt_arbiter (
  input  wire  logic                                    clk,
  input  wire  logic                                    srst,
  input  wire  logic [arbiter_pkg::NUM_CHAN-1:0]        chan_req,
  input  wire  logic [arbiter_pkg::NUM_CHAN*3-1:0]      channel_priority_level,
  input  wire  logic [arbiter_pkg::NUM_CHAN*8-1:0]      vector_select_reg,
  input  wire  logic                                    top_req,
  input  wire  logic                                    top_level_mask,
  input  wire  logic                                    top_level_nonmask,
  input  wire  logic                                    segment_save_enable,
  input  wire  logic [arbiter_pkg::SEG_W-1:0]           interrupt_segment_reg,
  input  wire  logic                                    instr_boundary,
  input  wire  logic                                    enable_interrupts_instr,
  input  wire  logic                                    iret_instr,
  input  wire  logic                                    ctrl_wr,
  input  wire  arbiter_pkg::ctrl_type                   ctrl_wdata,
  input  wire  logic                                    code_seg_wr,
  input  wire  logic [arbiter_pkg::SEG_W-1:0]           code_seg_wdata,
  input  wire  logic [15:0]                             cur_pc,
  input  wire  logic [7:0]                              cur_flags,
  input  wire  logic                                    pop_valid,
  input  wire  logic [7:0]                              pop_data,
  input  wire  logic                                    vec_valid,
  input  wire  logic [15:0]                             vec_data,
  output logic                                          ack_valid,
  output arbiter_pkg::ack_type                          ack_info,
  output arbiter_pkg::ctrl_type                         central_int_control_reg,
  output logic [7:0]                                    nested_level_stack_reg,
  output logic [arbiter_pkg::SEG_W-1:0]                 code_segment_reg,
  output logic [arbiter_pkg::SEG_W-1:0]                 fetch_segment,
  output logic                                          push_valid,
  output logic [7:0]                                    push_data,
  output logic                                          pop_req,
  output logic                                          vec_req,
  output logic [7:0]                                    vec_addr,
  output logic                                          pc_load,
  output logic [15:0]                                   pc_value,
  output logic                                          flags_load,
  output logic [7:0]                                    flags_value,
  output logic                                          busy
);
  import arbiter_pkg::*;

  // ------------------------------------------------------------
  // arbitration
  // ------------------------------------------------------------
  // lowest level wins; strict compare keeps earlier chain slot on ties
  function automatic logic [3:0] pick_winner(input logic [NUM_CHAN-1:0] req,
                                             input logic [NUM_CHAN*3-1:0] lvl);
    logic [3:0] best;
    logic [2:0] best_lvl;
    best     = 4'h8;
    best_lvl = 3'h7;
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (req[i] && (best[3] || lvl[i*3 +: 3] < best_lvl)) begin
        best     = 4'(i);
        best_lvl = lvl[i*3 +: 3];
      end
    end
    return best;
  endfunction : pick_winner

  function automatic logic [2:0] lowest_set(input logic [7:0] v);
    logic [2:0] idx;
    idx = LEVEL_RESET;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction : lowest_set

  seq_state_type      state_reg,  state_next;
  logic [2:0]         level_reg,  level_next;
  logic               enable_reg, enable_next;
  logic               mode_reg;
  logic [7:0]         level_stack_reg, level_stack_next;
  logic [SEG_W-1:0]   code_seg_reg, code_seg_next;
  logic               use_int_seg_reg;
  logic               top_active_reg;
  logic [15:0]        pc_save_reg;
  logic [7:0]         flags_save_reg;
  logic [7:0]         vec_sel_reg;
  logic               ack_valid_reg;
  ack_type            ack_reg;
  logic               push_valid_reg;
  logic [7:0]         push_data_reg;
  logic               pop_req_reg;
  logic               vec_req_reg;
  logic [15:0]        pc_value_reg;
  logic               pc_load_reg;
  logic [7:0]         flags_value_reg;
  logic               flags_load_reg;
  logic [SEG_W-1:0]   fetch_seg_reg;

  wire logic [3:0] win_idx   = pick_winner(chan_req, channel_priority_level);
  wire logic       win_any   = ~win_idx[3];
  wire logic [2:0] win_level = channel_priority_level[win_idx[2:0]*3 +: 3];
  // level 7 can never pass the strict compare, so it stays for polling
  wire logic       chan_ok   = win_any && enable_reg && (win_level < level_reg);
  wire logic       top_ok    = top_req && (top_level_nonmask || (top_level_mask && enable_reg));
  wire logic       arb_phase = (state_reg == ST_IDLE) && instr_boundary && !top_active_reg;
  wire logic       grant     = arb_phase && (top_ok || chan_ok);
  wire logic       grant_top = top_ok;
  wire logic       do_iret   = (state_reg == ST_IDLE) && iret_instr && !instr_boundary;
  wire logic       last_pop  = (state_reg == ST_POP_PCL) && pop_valid;

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:     if (grant) begin
                     state_next = ST_PUSH_PCL;
                   end else if (do_iret) begin
                     state_next = ST_POP_FLG;
                   end
      ST_PUSH_PCL: state_next = ST_PUSH_PCH;
      ST_PUSH_PCH: state_next = segment_save_enable ? ST_PUSH_SEG : ST_PUSH_FLG;
      ST_PUSH_SEG: state_next = ST_PUSH_FLG;
      ST_PUSH_FLG: state_next = ST_VEC;
      ST_VEC:      if (vec_valid) begin
                     state_next = ST_IDLE;
                   end
      ST_POP_FLG:  if (pop_valid) begin
                     state_next = segment_save_enable ? ST_POP_SEG : ST_POP_PCH;
                   end
      ST_POP_SEG:  if (pop_valid) begin
                     state_next = ST_POP_PCH;
                   end
      ST_POP_PCH:  if (pop_valid) begin
                     state_next = ST_POP_PCL;
                   end
      ST_POP_PCL:  if (pop_valid) begin
                     state_next = ST_IDLE;
                   end
      default:     state_next = ST_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // control state
  // ------------------------------------------------------------
  always_comb begin
    enable_next      = enable_reg;
    level_next       = level_reg;
    level_stack_next = level_stack_reg;
    if (ctrl_wr) begin
      enable_next = ctrl_wdata.int_enable;
      level_next  = ctrl_wdata.cur_level;
    end
    if (enable_interrupts_instr) begin
      enable_next = 1'b1;
    end
    // hardware acts override a same-cycle software write
    if (grant) begin
      enable_next = 1'b0;
      if (mode_reg && !grant_top) begin
        level_stack_next[level_reg] = 1'b1;
        level_next                  = win_level;
      end
    end
    if (last_pop) begin
      enable_next = 1'b1;
      if (mode_reg && !top_active_reg && (level_stack_reg != 8'h00)) begin
        level_next                                    = lowest_set(level_stack_reg);
        level_stack_next[lowest_set(level_stack_reg)] = 1'b0;
      end
    end
  end

  always_comb begin
    code_seg_next = code_seg_reg;
    if (code_seg_wr) begin
      code_seg_next = code_seg_wdata;
    end
    if (state_reg == ST_PUSH_SEG) begin
      code_seg_next = interrupt_segment_reg;
    end
    if (state_reg == ST_POP_SEG && pop_valid) begin
      code_seg_next = pop_data[SEG_W-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg      <= ST_IDLE;
      level_reg       <= LEVEL_RESET;
      enable_reg      <= ENABLE_RESET;
      mode_reg        <= MODE_RESET;
      level_stack_reg <= LEVEL_STACK_RESET;
      code_seg_reg    <= '0;
      use_int_seg_reg <= 1'b0;
      top_active_reg  <= 1'b0;
    end else begin
      state_reg       <= state_next;
      level_reg       <= level_next;
      enable_reg      <= enable_next;
      level_stack_reg <= level_stack_next;
      code_seg_reg    <= code_seg_next;
      if (ctrl_wr) begin
        mode_reg <= ctrl_wdata.mode;
      end
      if (grant && !segment_save_enable) begin
        use_int_seg_reg <= 1'b1;
      end else if (last_pop) begin
        use_int_seg_reg <= 1'b0;
      end
      if (grant && grant_top) begin
        top_active_reg <= 1'b1;
      end else if (last_pop) begin
        top_active_reg <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // frame capture and output flops
  // ------------------------------------------------------------
  wire logic [7:0] win_vec = grant_top ? TOP_VECTOR : vector_select_reg[win_idx[2:0]*8 +: 8];
  wire logic [7:0] push_d  = (state_reg == ST_PUSH_PCL) ? pc_save_reg[7:0]  :
                             (state_reg == ST_PUSH_PCH) ? pc_save_reg[15:8] :
                             (state_reg == ST_PUSH_SEG) ? code_seg_reg[7:0] : flags_save_reg;
  wire logic       pushing = (state_reg == ST_PUSH_PCL) || (state_reg == ST_PUSH_PCH) ||
                             (state_reg == ST_PUSH_SEG) || (state_reg == ST_PUSH_FLG);
  wire logic       popping = (state_next == ST_POP_FLG) || (state_next == ST_POP_SEG) ||
                             (state_next == ST_POP_PCH) || (state_next == ST_POP_PCL);

  always_ff @(posedge clk) begin
    if (srst) begin
      pc_save_reg     <= '0;
      flags_save_reg  <= '0;
      vec_sel_reg     <= '0;
      ack_valid_reg   <= 1'b0;
      ack_reg         <= '0;
      push_valid_reg  <= 1'b0;
      push_data_reg   <= '0;
      pop_req_reg     <= 1'b0;
      vec_req_reg     <= 1'b0;
      pc_value_reg    <= '0;
      pc_load_reg     <= 1'b0;
      flags_value_reg <= '0;
      flags_load_reg  <= 1'b0;
      fetch_seg_reg   <= '0;
    end else begin
      ack_valid_reg  <= grant;
      push_valid_reg <= pushing;
      push_data_reg  <= push_d;
      pop_req_reg    <= popping;
      vec_req_reg    <= (state_next == ST_VEC);
      pc_load_reg    <= (state_reg == ST_VEC && vec_valid) || last_pop;
      flags_load_reg <= (state_reg == ST_POP_FLG) && pop_valid;
      fetch_seg_reg  <= (use_int_seg_reg && !last_pop) ? interrupt_segment_reg : code_seg_next;
      if (grant) begin
        pc_save_reg    <= cur_pc;
        flags_save_reg <= cur_flags;
        vec_sel_reg    <= win_vec;
        ack_reg.top    <= grant_top;
        ack_reg.chan   <= grant_top ? 8'h00 : (8'h01 << win_idx[2:0]);
      end
      if (state_reg == ST_VEC && vec_valid) begin
        pc_value_reg <= vec_data;
      end
      if (state_reg == ST_POP_FLG && pop_valid) begin
        flags_value_reg <= pop_data;
      end
      if (state_reg == ST_POP_PCH && pop_valid) begin
        pc_value_reg[15:8] <= pop_data;
      end
      if (last_pop) begin
        pc_value_reg[7:0] <= pop_data;
      end
    end
  end

  assign ack_valid               = ack_valid_reg;
  assign ack_info                = ack_reg;
  assign central_int_control_reg = '{int_enable: enable_reg, mode: mode_reg, cur_level: level_reg};
  assign nested_level_stack_reg  = level_stack_reg;
  assign code_segment_reg        = code_seg_reg;
  assign fetch_segment           = fetch_seg_reg;
  assign push_valid              = push_valid_reg;
  assign push_data               = push_data_reg;
  assign pop_req                 = pop_req_reg;
  assign vec_req                 = vec_req_reg;
  assign vec_addr                = vec_sel_reg;
  assign pc_load                 = pc_load_reg;
  assign pc_value                = pc_value_reg;
  assign flags_load              = flags_load_reg;
  assign flags_value             = flags_value_reg;
  assign busy                    = (state_reg != ST_IDLE);

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  chk_ack_strict_level: assert property (
    ack_valid_reg && !ack_reg.top |-> $past(win_level) < $past(level_reg))
    else $error("channel acknowledged without beating current level");
  chk_ack_clears_enable: assert property (
    ack_valid_reg |-> !enable_reg)
    else $error("enable not cleared on acknowledge");
  chk_push_pc_order: assert property (
    ack_valid_reg |=> push_valid_reg && push_data_reg == pc_save_reg[7:0]
                      ##1 push_valid_reg && push_data_reg == pc_save_reg[15:8])
    else $error("pc bytes not pushed low then high");
  chk_no_seg_push: assert property (
    state_reg == ST_PUSH_PCH && !segment_save_enable |=> state_reg == ST_PUSH_FLG)
    else $error("code segment pushed with saving off");
  chk_seg_loaded: assert property (
    state_reg == ST_PUSH_SEG |=> code_seg_reg == $past(interrupt_segment_reg))
    else $error("code segment not loaded from interrupt segment");
  chk_concurrent_level: assert property (
    ack_valid_reg && !$past(mode_reg) && !$past(ctrl_wr) |-> $stable(level_reg))
    else $error("level changed in concurrent mode");
  chk_nested_record: assert property (
    ack_valid_reg && $past(mode_reg) && !ack_reg.top
      |-> level_reg == $past(win_level) && level_stack_reg[$past(level_reg)])
    else $error("nested level not recorded and loaded");
  chk_top_not_broken: assert property (
    top_active_reg && state_reg == ST_IDLE && !last_pop |=> !ack_valid_reg)
    else $error("top level routine interrupted");
  chk_iret_restores: assert property (
    last_pop |=> enable_reg && pc_load_reg && !use_int_seg_reg)
    else $error("return did not restore enable and segment");

  cov_top_ack:    cover property (ack_valid_reg && ack_reg.top);
  cov_nested_ack: cover property (ack_valid_reg && mode_reg && level_stack_reg != 8'h00);
  cov_seg_frame:  cover property (state_reg == ST_POP_SEG && pop_valid);
endmodule : priority_interrupt_arbiter

// *** logic/arbiter_pkg.sv ***
// Summary of operation
// - segment save off: use interrupt segment, stack pc+flags
// - segment save on: push code segment, load from interrupt
// - segment save on: return restores code segment
// - each channel has 3-bit level, 0 highest
// - top level overrides all, never interrupted
// - current level is 3 bits, 7 after reset
// - arbitrate all pending requests every instruction
// - acknowledge only if level below current level
// - same level cannot interrupt running routine; code enforces it in nested mode only, concurrent mode acks it once re-enabled
// - equal levels resolved by fixed chain order
// - software reads and writes current level anytime
// - mode bit: 0 concurrent, level unchanged there
// - ack: clear enable, push pc, seg, flags, vector
// - return: pop flags, seg, pc, enable, revert segment
// - requests stay pending until interrupts re-enabled
// - concurrent mode keeps no routine level record
// - without re-enable, serve pending one by one
// - nested: record level in stack bit, load, restore
package arbiter_pkg;
  localparam int          NUM_CHAN    = 8;
  localparam int          LEVEL_W     = 3;
  localparam int          SEG_W       = 8;
  localparam logic [2:0]  LEVEL_RESET       = 3'h7;
  localparam logic [7:0]  TOP_VECTOR        = 8'h04;
  localparam logic [7:0]  LEVEL_STACK_RESET = 8'h00;
  localparam logic        MODE_RESET        = 1'b0;
  localparam logic        ENABLE_RESET      = 1'b0;

  typedef struct packed {
    logic       int_enable;
    logic       mode;
    logic [2:0] cur_level;
  } ctrl_type;

  typedef struct packed {
    logic [7:0] chan;
    logic       top;
  } ack_type;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_PUSH_PCL = 4'h1,
    ST_PUSH_PCH = 4'h2,
    ST_PUSH_SEG = 4'h3,
    ST_PUSH_FLG = 4'h4,
    ST_VEC      = 4'h5,
    ST_POP_FLG  = 4'h6,
    ST_POP_SEG  = 4'h7,
    ST_POP_PCH  = 4'h8,
    ST_POP_PCL  = 4'h9
  } seq_state_type;
endpackage : arbiter_pkg

// *** verification/stack_partner.sv ***
`timescale 1ns/1ps
module stack_partner (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        slow,
  input  wire logic        push_valid,
  input  wire logic [7:0]  push_data,
  input  wire logic        pop_req,
  output logic             pop_valid = 1'b0,
  output logic [7:0]       pop_data  = 8'h00,
  input  wire logic        vec_req,
  input  wire logic [7:0]  vec_addr,
  output logic             vec_valid = 1'b0,
  output logic [15:0]      vec_data  = 16'h0000
);
  logic [7:0] stack [$];
  int         wait_cnt = 0;

  // ----------------------------------------
  // system stack and vector table
  // ----------------------------------------
  // a gap cycle follows every answer, so a request that falls a cycle late never gets a stray byte
  always @(posedge clk) begin
    if (push_valid) begin
      stack.push_back(push_data);
    end
    pop_valid <= 1'b0;
    vec_valid <= 1'b0;
    // released data lines toggle rather than hold the last value
    pop_data  <= ~pop_data;
    vec_data  <= ~vec_data;
    if (srst || pop_valid || vec_valid || !(pop_req || vec_req)) begin
      wait_cnt <= 0;
    end else if (wait_cnt < (slow ? 3 : 0)) begin
      wait_cnt <= wait_cnt + 1;
    end else if (pop_req) begin
      pop_valid <= 1'b1;
      pop_data  <= stack.pop_back();
    end else begin
      vec_valid <= 1'b1;
      vec_data  <= {~vec_addr, vec_addr};
    end
  end
endmodule : stack_partner

// *** verification/test_priority_interrupt_arbiter.sv ***
`timescale 1ns/1ps
module test_priority_interrupt_arbiter;
  import arbiter_pkg::*;
  logic        clk = 1'b0, srst = 1'b1, slow = 1'b0, save_en = 1'b0;
  logic        boundary = 1'b0, en_instr = 1'b0, iret = 1'b0, ctrl_wr = 1'b0, seg_wr = 1'b0;
  logic        top_req = 1'b0, top_mask = 1'b0, top_nonmask = 1'b0;
  logic [7:0]  chan_req = 8'h00, int_seg = 8'h5a, seg_wdata = 8'h21, cur_flags = 8'h3c;
  logic [23:0] levels = 24'hffffff;
  logic [63:0] vectors = 64'h5c58_5450_4c48_4440;
  logic [15:0] cur_pc = 16'h1234;
  ctrl_type    ctrl_wdata = '0, ctrl_seen;
  ack_type     ack_info;
  logic        ack_valid, push_valid, pop_req, pop_valid, vec_req, vec_valid, pc_load, flags_load, busy;
  logic [7:0]  lvl_stack, code_seg, fetch_seg, push_data, pop_data, vec_addr, flags_value;
  logic [15:0] vec_data, pc_value;
  int          mismatches = 0, comparisons = 0, cycles = 0;

  always #5 clk = ~clk;

  priority_interrupt_arbiter uut (.clk(clk), .srst(srst), .chan_req(chan_req), .channel_priority_level(levels),
    .vector_select_reg(vectors), .top_req(top_req), .top_level_mask(top_mask), .top_level_nonmask(top_nonmask),
    .segment_save_enable(save_en), .interrupt_segment_reg(int_seg), .instr_boundary(boundary),
    .enable_interrupts_instr(en_instr), .iret_instr(iret), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
    .code_seg_wr(seg_wr), .code_seg_wdata(seg_wdata), .cur_pc(cur_pc), .cur_flags(cur_flags),
    .pop_valid(pop_valid), .pop_data(pop_data), .vec_valid(vec_valid), .vec_data(vec_data), .ack_valid(ack_valid),
    .ack_info(ack_info), .central_int_control_reg(ctrl_seen), .nested_level_stack_reg(lvl_stack),
    .code_segment_reg(code_seg), .fetch_segment(fetch_seg), .push_valid(push_valid), .push_data(push_data),
    .pop_req(pop_req), .vec_req(vec_req), .vec_addr(vec_addr), .pc_load(pc_load), .pc_value(pc_value),
    .flags_load(flags_load), .flags_value(flags_value), .busy(busy));

  stack_partner p (.clk(clk), .srst(srst), .slow(slow), .push_valid(push_valid), .push_data(push_data),
    .pop_req(pop_req), .pop_valid(pop_valid), .pop_data(pop_data), .vec_req(vec_req),
    .vec_addr(vec_addr), .vec_valid(vec_valid), .vec_data(vec_data));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic set_ctrl(input logic en, input logic mode, input logic [2:0] lvl);
    ctrl_wdata = {en, mode, lvl};
    ctrl_wr = 1'b1;
    tick(1);
    ctrl_wr = 1'b0;
  endtask : set_ctrl

  task automatic pulse_enable();
    en_instr = 1'b1;
    tick(1);
    en_instr = 1'b0;
  endtask : pulse_enable

  task automatic enter(input logic exp, input logic [8:0] info, input logic [7:0] vec);
    logic        got;
    logic        seen_pc;
    logic [15:0] pc;
    got = 1'b0;
    seen_pc = 1'b0;
    pc = 16'h0000;
    boundary = 1'b1;
    tick(1);
    boundary = 1'b0;
    for (int i = 0; i < 40; i++) begin
      if (ack_valid) got = 1'b1;
      if (pc_load) begin
        pc = pc_value;
        seen_pc = 1'b1;
      end
      if (i > 2 && !busy && (seen_pc || !got)) break;
      tick(1);
    end
    check(got, exp);
    if (exp) begin
      check(ack_info, info);
      check(pc, {~vec, vec});
      check(ctrl_seen.int_enable, 1'b0);
    end
  endtask : enter

  task automatic leave(input logic [15:0] exp_pc);
    logic        done;
    logic [15:0] pc;
    logic [7:0]  fl;
    done = 1'b0;
    pc = 16'h0000;
    fl = 8'h00;
    iret = 1'b1;
    tick(1);
    iret = 1'b0;
    for (int i = 0; i < 60 && !(done && !busy); i++) begin
      if (flags_load) fl = flags_value;
      if (pc_load) begin
        pc = pc_value;
        done = 1'b1;
      end
      tick(1);
    end
    check({pc, fl}, {exp_pc, cur_flags});
    check(ctrl_seen.int_enable, 1'b1);
    check(fetch_seg, code_seg);
  endtask : leave

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic s_reset_and_refuse();
    check(ctrl_seen, 5'h07);
    check(lvl_stack, 8'h00);
    levels[8:6] = 3'h0;
    chan_req = 8'h04;
    enter(1'b0, 9'h000, 8'h00);
    set_ctrl(1'b1, 1'b0, 3'h3);
    check(ctrl_seen, 5'h13);
    levels[8:6] = 3'h3;
    enter(1'b0, 9'h000, 8'h00);
    set_ctrl(1'b1, 1'b0, 3'h7);
    levels[8:6] = 3'h7;
    enter(1'b0, 9'h000, 8'h00);
    chan_req = 8'h00;
  endtask : s_reset_and_refuse

  task automatic s_concurrent();
    levels = 24'hf8ffff;
    levels[5:3] = 3'h4;
    chan_req = 8'h62;
    enter(1'b1, 9'h040, 8'h54);
    check({p.stack.size(), p.stack[0], p.stack[1], p.stack[2]}, 32'h0334123c);
    check({fetch_seg, 5'(ctrl_seen.cur_level)}, {int_seg, 5'h07});
    chan_req = 8'h40;
    enter(1'b0, 9'h000, 8'h00);
    slow = 1'b1;
    leave(16'h1234);
    slow = 1'b0;
    enter(1'b1, 9'h080, 8'h58);
    chan_req = 8'h02;
    pulse_enable();
    cur_pc = 16'h5678;
    enter(1'b1, 9'h004, 8'h44);
    chan_req = 8'h00;
    leave(16'h5678);
    leave(16'h1234);
    check(p.stack.size(), 0);
  endtask : s_concurrent

  task automatic s_segment_save();
    save_en = 1'b1;
    seg_wr = 1'b1;
    tick(1);
    seg_wr = 1'b0;
    levels[2:0] = 3'h1;
    chan_req = 8'h01;
    cur_pc = 16'hbeef;
    enter(1'b1, 9'h002, 8'h40);
    check({p.stack[0], p.stack[1], p.stack[2], p.stack[3]}, 32'hefbe213c);
    check(code_seg, int_seg);
    chan_req = 8'h00;
    leave(16'hbeef);
    check(code_seg, 8'h21);
    save_en = 1'b0;
  endtask : s_segment_save

  task automatic s_nested();
    set_ctrl(1'b1, 1'b1, 3'h5);
    levels[5:0] = 6'h12;
    chan_req = 8'h01;
    cur_pc = 16'h1111;
    enter(1'b1, 9'h002, 8'h40);
    check({lvl_stack, 5'(ctrl_seen.cur_level)}, {8'h20, 5'h02});
    chan_req = 8'h02;
    pulse_enable();
    enter(1'b0, 9'h000, 8'h00);
    levels[5:3] = 3'h1;
    cur_pc = 16'h2222;
    enter(1'b1, 9'h004, 8'h44);
    check({lvl_stack, 5'(ctrl_seen.cur_level)}, {8'h24, 5'h01});
    chan_req = 8'h00;
    leave(16'h2222);
    check({lvl_stack, 5'(ctrl_seen.cur_level)}, {8'h20, 5'h02});
    leave(16'h1111);
    check({lvl_stack, 5'(ctrl_seen.cur_level)}, {8'h00, 5'h05});
  endtask : s_nested

  task automatic s_top_level();
    set_ctrl(1'b1, 1'b0, 3'h7);
    levels[2:0] = 3'h0;
    chan_req = 8'h01;
    top_req = 1'b1;
    top_nonmask = 1'b1;
    cur_pc = 16'h0abc;
    enter(1'b1, 9'h001, TOP_VECTOR);
    top_req = 1'b0;
    pulse_enable();
    enter(1'b0, 9'h000, 8'h00);
    leave(16'h0abc);
    chan_req = 8'h00;
  endtask : s_top_level

  // ----------------------------------------
  // run control
  // ----------------------------------------
  // scenarios need well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      end_of_test();
    end
  end

  initial begin
    tick(6);
    srst = 1'b0;
    tick(1);
    s_reset_and_refuse();
    s_concurrent();
    s_segment_save();
    s_nested();
    s_top_level();
    end_of_test();
  end
endmodule : test_priority_interrupt_arbiter
